// ---- verilog/cidc_defs.vh ----
// register map, field positions, reset values and codes of the clock input divider control
`ifndef CIDC_DEFS_VH
`define CIDC_DEFS_VH
`define CIDC_IDX_RATIO 12'h1E0
`define CIDC_IDX_INPATH 12'h1E1
`define CIDC_IDX_SYSPWR 12'h230
`define CIDC_IDX_UPDATE 12'h232
`define CIDC_IDX_CHAN 12'h240
`define CIDC_IDX_STATUS 12'h241
`define CIDC_RATIO_MSB 2
`define CIDC_RATIO_RST 3'h2
`define CIDC_INPATH_MSB 4
`define CIDC_INPATH_RST 5'h00
`define CIDC_BIT_PD_INSEC 4
`define CIDC_BIT_PD_CLKIF 3
`define CIDC_BIT_PD_SRC 2
`define CIDC_BIT_SRC_OSC 1
`define CIDC_BIT_BYPASS 0
`define CIDC_SYSPWR_MSB 2
`define CIDC_SYSPWR_RST 3'h0
`define CIDC_BIT_SYNC_PD 2
`define CIDC_BIT_DREF_PD 1
`define CIDC_BIT_SOFT_SYNC 0
`define CIDC_BIT_UPDATE 0
`define CIDC_CHAN_DIR_LSB 8
`define CIDC_ST_SYNC_ACT 0
`define CIDC_ST_CONFLICT 1
`define CIDC_ST_STATIC 2
`define CIDC_ST_PIN_SYNC 3
`define CIDC_ST_UPD_BUSY 4
`define CIDC_SRC_OSC_DIRECT 2'h2
`define CIDC_SRC_EXT_DIRECT 2'h0
`define CIDC_CODE_DIV2 3'h0
`define CIDC_CODE_DIV3 3'h1
`define CIDC_CODE_DIV4 3'h2
`define CIDC_CODE_DIV5 3'h3
`define CIDC_CODE_DIV6 3'h4
`define CIDC_RATIO_2 3'h2
`define CIDC_RATIO_3 3'h3
`define CIDC_RATIO_4 3'h4
`define CIDC_RATIO_5 3'h5
`define CIDC_RATIO_6 3'h6
`define CIDC_RATIO_STATIC 3'h0
`define CIDC_RESP_OKAY 2'h0
`define CIDC_RESP_SLVERR 2'h2
`endif

// ---- verilog/cidc_sync3.v ----
// three-stage pin synchroniser; output moves only when stages two and three agree
module cidc_sync3
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
    input wire i_sys_clk, // system clock
    input wire i_rst, // async reset, active high
    input wire [WIDTH-1:0] i_pin, // asynchronous pin levels
    output reg [WIDTH-1:0] o_level // filtered synchronous levels
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    integer k;

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            o_level <= RST_VAL;
        end
        else
        begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (k = 0; k < WIDTH; k = k + 1)
            begin
                if (s2_reg[k] == s3_reg[k])
                    o_level[k] <= s3_reg[k];
            end
        end
    end
endmodule

// ---- verilog/cidc_prediv.v ----
// programmable pre-divider: divide by 2..6, static, bypass, power-down
`include "cidc_defs.vh"
module cidc_prediv
(
    input wire i_sys_clk, // system clock
    input wire i_rst, // async reset, active high
    input wire i_in_level, // synchronised selected input level
    input wire [2:0] i_code, // active ratio code
    input wire i_bypass, // pass input around the divider
    input wire i_pd, // clock input section powered down
    output reg o_out // divider output
);
    reg in_prev_reg;
    reg [2:0] cnt_reg;
    reg [2:0] ratio;
    wire rise;
    wire [2:0] cnt_next;

    always @*
    begin
        case (i_code)
            `CIDC_CODE_DIV2: ratio = `CIDC_RATIO_2;
            `CIDC_CODE_DIV3: ratio = `CIDC_RATIO_3;
            `CIDC_CODE_DIV4: ratio = `CIDC_RATIO_4;
            `CIDC_CODE_DIV5: ratio = `CIDC_RATIO_5;
            `CIDC_CODE_DIV6: ratio = `CIDC_RATIO_6;
            default: ratio = `CIDC_RATIO_STATIC;
        endcase
    end

    assign rise = i_in_level & ~in_prev_reg;
    assign cnt_next = (cnt_reg + 3'h1 >= ratio) ? 3'h0 : cnt_reg + 3'h1;

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            in_prev_reg <= 1'b0;
            cnt_reg <= 3'h0;
            o_out <= 1'b0;
        end
        else
        begin
            in_prev_reg <= i_in_level;
            if (i_pd)
            begin
                cnt_reg <= 3'h0;
                o_out <= 1'b0;
            end
            else if (i_bypass)
            begin
                cnt_reg <= 3'h0;
                o_out <= i_in_level;
            end
            else if (ratio == `CIDC_RATIO_STATIC)
            begin
                cnt_reg <= 3'h0;
                o_out <= 1'b0;
            end
            else if (rise)
            begin
                cnt_reg <= cnt_next;
                o_out <= (cnt_next < {1'b0, ratio[2:1]});
            end
        end
    end
endmodule

// ---- verilog/cidc_top.v ----
// clock input divider control: AXI4-Lite registers, buffered/active config, sync and pre-divider
//
// The AXI4-Lite register port is this design's own decision.
`include "cidc_defs.vh"
module cidc_top
#(
    parameter ADDR_W = 14,
    parameter NUM_CHAN = 3
)
(
    input wire i_sys_clk, // system clock, 20 MHz
    input wire i_rst, // async reset, active high
    input wire [ADDR_W-1:0] i_awaddr, // write address (byte)
    input wire i_awvalid, // write address valid
    output reg o_awready, // write address ready
    input wire [31:0] i_wdata, // write data
    input wire [3:0] i_wstrb, // write byte strobes
    input wire i_wvalid, // write data valid
    output reg o_wready, // write data ready
    output reg [1:0] o_bresp, // write response
    output reg o_bvalid, // write response valid
    input wire i_bready, // write response ready
    input wire [ADDR_W-1:0] i_araddr, // read address (byte)
    input wire i_arvalid, // read address valid
    output reg o_arready, // read address ready
    output reg [31:0] o_rdata, // read data
    output reg [1:0] o_rresp, // read response
    output reg o_rvalid, // read data valid
    input wire i_rready, // read data ready
    input wire i_ext_clk, // external clock pin
    input wire i_osc_clk, // internal oscillator clock
    input wire i_sync_n, // chip sync pin, active low
    output wire o_prediv_out, // pre-divider output
    output wire o_input_section_pd, // clock input section powered down
    output wire o_clk_if_pd, // oscillator interface powered down
    output wire o_src_pd, // oscillator and external input powered down
    output wire o_src_sel_osc, // divider input is the oscillator
    output wire o_bypass, // raw bypass bit; the divider ignores it when the oscillator is selected
    output wire o_sync_pd, // sync circuitry powered down
    output wire o_dist_ref_pd, // distribution reference powered down
    output reg [NUM_CHAN-1:0] o_chan_hold, // channel held static
    output reg [NUM_CHAN-1:0] o_chan_sync, // channel sync pulse
    output reg [NUM_CHAN-1:0] o_chan_osc_direct, // oscillator straight to channel outputs
    output reg [NUM_CHAN-1:0] o_chan_ext_direct // external clock straight to channel outputs
);
    // buffered (software-visible) copies
    reg [`CIDC_RATIO_MSB:0] buf_ratio_reg;
    reg [`CIDC_INPATH_MSB:0] buf_path_reg;
    reg [`CIDC_SYSPWR_MSB:0] buf_sys_reg;
    reg [NUM_CHAN-1:0] buf_ign_reg;
    reg [NUM_CHAN-1:0] buf_dir_reg;
    // active copies steering the hardware
    reg [`CIDC_RATIO_MSB:0] act_ratio_reg;
    reg [`CIDC_INPATH_MSB:0] act_path_reg;
    reg [`CIDC_SYSPWR_MSB:0] act_sys_reg;
    reg [NUM_CHAN-1:0] act_ign_reg;
    reg [NUM_CHAN-1:0] act_dir_reg;
    reg update_reg;
    // write channel state
    reg aw_full_reg;
    reg w_full_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    // sync state
    reg sync_act_reg;
    reg sync_act_next;
    reg [31:0] rd_data_next;
    reg rd_hit_next;
    reg wr_hit;
    wire do_write;
    wire [11:0] wr_idx;
    wire [11:0] rd_idx;
    wire wr_lane0;
    wire wr_lane1;
    wire ext_level;
    wire osc_level;
    wire sync_n_level;
    wire sel_level;
    wire eff_bypass;
    wire conflict;
    wire [1:0] src_byp;

    // the write fires only once both halves are in, so a pair always lands as one
    assign do_write = aw_full_reg & w_full_reg & ~o_bvalid;
    assign wr_idx = aw_addr_reg[13:2];
    assign rd_idx = i_araddr[13:2];
    assign wr_lane0 = wstrb_reg[0];
    assign wr_lane1 = wstrb_reg[1];

    always @*
    begin
        case (wr_idx)
            `CIDC_IDX_RATIO: wr_hit = 1'b1;
            `CIDC_IDX_INPATH: wr_hit = 1'b1;
            `CIDC_IDX_SYSPWR: wr_hit = 1'b1;
            `CIDC_IDX_UPDATE: wr_hit = 1'b1;
            `CIDC_IDX_CHAN: wr_hit = 1'b1;
            `CIDC_IDX_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write address and data are taken independently, then answered together
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= `CIDC_RESP_OKAY;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_addr_reg <= i_awaddr;
                aw_full_reg <= 1'b1;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
                w_full_reg <= 1'b1;
                o_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_hit ? `CIDC_RESP_OKAY : `CIDC_RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
            begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // software writes only touch the buffer copies
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            buf_ratio_reg <= `CIDC_RATIO_RST;
            buf_path_reg <= `CIDC_INPATH_RST;
            buf_sys_reg <= `CIDC_SYSPWR_RST;
            buf_ign_reg <= {NUM_CHAN{1'b0}};
            buf_dir_reg <= {NUM_CHAN{1'b0}};
        end
        else
        begin
            if (do_write && wr_lane0)
            begin
                case (wr_idx)
                    `CIDC_IDX_RATIO: buf_ratio_reg <= wdata_reg[`CIDC_RATIO_MSB:0];
                    `CIDC_IDX_INPATH: buf_path_reg <= wdata_reg[`CIDC_INPATH_MSB:0];
                    `CIDC_IDX_SYSPWR: buf_sys_reg <= wdata_reg[`CIDC_SYSPWR_MSB:0];
                    `CIDC_IDX_CHAN: buf_ign_reg <= wdata_reg[NUM_CHAN-1:0];
                    default: buf_ign_reg <= buf_ign_reg;
                endcase
            end
            if (do_write && wr_lane1 && wr_idx == `CIDC_IDX_CHAN)
                buf_dir_reg <= wdata_reg[`CIDC_CHAN_DIR_LSB+NUM_CHAN-1:`CIDC_CHAN_DIR_LSB];
        end
    end

    // update command: a new request wins over the self-clear
    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            update_reg <= 1'b0;
        else if (do_write && wr_lane0 && wr_idx == `CIDC_IDX_UPDATE && wdata_reg[`CIDC_BIT_UPDATE])
            update_reg <= 1'b1;
        else if (update_reg)
            update_reg <= 1'b0;
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            act_ratio_reg <= `CIDC_RATIO_RST;
            act_path_reg <= `CIDC_INPATH_RST;
            act_sys_reg <= `CIDC_SYSPWR_RST;
            act_ign_reg <= {NUM_CHAN{1'b0}};
            act_dir_reg <= {NUM_CHAN{1'b0}};
        end
        // all active copies move on one edge, so no half-updated setup is ever live
        else if (update_reg)
        begin
            act_ratio_reg <= buf_ratio_reg;
            act_path_reg <= buf_path_reg;
            act_sys_reg <= buf_sys_reg;
            act_ign_reg <= buf_ign_reg;
            act_dir_reg <= buf_dir_reg;
        end
    end

    // the oscillator cannot skip the divider, so bypass is dropped in that case
    assign conflict = act_path_reg[`CIDC_BIT_SRC_OSC] & act_path_reg[`CIDC_BIT_BYPASS];
    assign eff_bypass = act_path_reg[`CIDC_BIT_BYPASS] & ~act_path_reg[`CIDC_BIT_SRC_OSC];
    assign src_byp = {act_path_reg[`CIDC_BIT_SRC_OSC], act_path_reg[`CIDC_BIT_BYPASS]};

    always @*
    begin
        // config reads show the buffer, so a write reads back before any update; status shows the active copies
        rd_hit_next = 1'b1;
        rd_data_next = 32'h00000000;
        case (rd_idx)
            `CIDC_IDX_RATIO: rd_data_next[`CIDC_RATIO_MSB:0] = buf_ratio_reg;
            `CIDC_IDX_INPATH: rd_data_next[`CIDC_INPATH_MSB:0] = buf_path_reg;
            `CIDC_IDX_SYSPWR: rd_data_next[`CIDC_SYSPWR_MSB:0] = buf_sys_reg;
            `CIDC_IDX_UPDATE: rd_data_next[`CIDC_BIT_UPDATE] = update_reg;
            `CIDC_IDX_CHAN:
            begin
                rd_data_next[NUM_CHAN-1:0] = buf_ign_reg;
                rd_data_next[`CIDC_CHAN_DIR_LSB+NUM_CHAN-1:`CIDC_CHAN_DIR_LSB] = buf_dir_reg;
            end
            `CIDC_IDX_STATUS:
            begin
                rd_data_next[`CIDC_ST_SYNC_ACT] = sync_act_reg;
                rd_data_next[`CIDC_ST_CONFLICT] = conflict;
                rd_data_next[`CIDC_ST_STATIC] = (act_ratio_reg > `CIDC_CODE_DIV6);
                rd_data_next[`CIDC_ST_PIN_SYNC] = ~sync_n_level;
                rd_data_next[`CIDC_ST_UPD_BUSY] = update_reg;
            end
            default: rd_hit_next = 1'b0;
        endcase
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `CIDC_RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_data_next;
            o_rresp <= rd_hit_next ? `CIDC_RESP_OKAY : `CIDC_RESP_SLVERR;
        end
        else if (o_rvalid && i_rready)
        begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // the sync pin resets to its idle high level, so reset never fakes a sync
    cidc_sync3 #(
        .WIDTH(3),
        .RST_VAL(3'h4)
    ) u_pins (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pin({i_sync_n, i_osc_clk, i_ext_clk}),
        .o_level({sync_n_level, osc_level, ext_level})
    );

    // a powered-down source delivers no edges
    assign sel_level = act_path_reg[`CIDC_BIT_PD_SRC] ? 1'b0 :
        (act_path_reg[`CIDC_BIT_SRC_OSC] ? osc_level : ext_level);

    // the divider gets the corrected bypass; o_bypass still reports the raw bit
    cidc_prediv u_prediv (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_in_level(sel_level),
        .i_code(act_ratio_reg),
        .i_bypass(eff_bypass),
        .i_pd(act_path_reg[`CIDC_BIT_PD_INSEC]),
        .o_out(o_prediv_out)
    );

    assign o_input_section_pd = act_path_reg[`CIDC_BIT_PD_INSEC];
    assign o_clk_if_pd = act_path_reg[`CIDC_BIT_PD_CLKIF];
    assign o_src_pd = act_path_reg[`CIDC_BIT_PD_SRC];
    assign o_src_sel_osc = act_path_reg[`CIDC_BIT_SRC_OSC];
    assign o_bypass = act_path_reg[`CIDC_BIT_BYPASS];
    assign o_sync_pd = act_sys_reg[`CIDC_BIT_SYNC_PD];
    assign o_dist_ref_pd = act_sys_reg[`CIDC_BIT_DREF_PD];

    // soft sync is the pin with its polarity reversed; both feed one chip-level sync
    always @*
    begin
        sync_act_next = ~act_sys_reg[`CIDC_BIT_SYNC_PD] &
            (act_sys_reg[`CIDC_BIT_SOFT_SYNC] | ~sync_n_level);
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_act_reg <= 1'b0;
            o_chan_hold <= {NUM_CHAN{1'b0}};
            o_chan_sync <= {NUM_CHAN{1'b0}};
            o_chan_osc_direct <= {NUM_CHAN{1'b0}};
            o_chan_ext_direct <= {NUM_CHAN{1'b0}};
        end
        else
        begin
            sync_act_reg <= sync_act_next;
            o_chan_hold <= {NUM_CHAN{sync_act_next}} & ~act_ign_reg;
            // a power-down of sync releases the hold silently, without a sync pulse
            o_chan_sync <= {NUM_CHAN{sync_act_reg & ~sync_act_next & ~act_sys_reg[`CIDC_BIT_SYNC_PD]}}
                & ~act_ign_reg;
            // source/bypass 01b leaves a direct channel on its divider
            o_chan_osc_direct <= act_dir_reg
                & {NUM_CHAN{src_byp == `CIDC_SRC_OSC_DIRECT}};
            o_chan_ext_direct <= act_dir_reg
                & {NUM_CHAN{src_byp == `CIDC_SRC_EXT_DIRECT}};
        end
    end
endmodule

// ---- testbench/cidc_chk.sv ----
// concurrent checks on the ports of the clock input divider control
module cidc_chk
#(
    parameter NUM_CHAN = 3
)
(
    input wire logic i_sys_clk, // clock
    input wire logic i_rst, // async reset
    input wire logic i_awvalid, // aw valid
    input wire logic o_awready, // aw ready
    input wire logic i_wvalid, // w valid
    input wire logic o_wready, // w ready
    input wire logic o_bvalid, // b valid
    input wire logic i_bready, // b ready
    input wire logic i_arvalid, // ar valid
    input wire logic o_arready, // ar ready
    input wire logic o_rvalid, // r valid
    input wire logic [31:0] o_rdata, // read data
    input wire logic i_rready, // r ready
    input wire logic o_prediv_out, // divider output
    input wire logic o_input_section_pd, // input section off
    input wire logic o_sync_pd, // sync off
    input wire logic [NUM_CHAN-1:0] o_chan_hold, // channel held
    input wire logic [NUM_CHAN-1:0] o_chan_sync, // sync pulse
    input wire logic [NUM_CHAN-1:0] o_chan_osc_direct, // osc direct
    input wire logic [NUM_CHAN-1:0] o_chan_ext_direct // ext direct
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("no write response after address and data");
    a_resp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    a_busy_while_pending: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write ready while response pending");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("no read data after read address");
    a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data changed before taken");
    a_pd_quiets_div: assert property (o_input_section_pd && $past(o_input_section_pd) |-> !o_prediv_out)
        else $error("divider runs while input section is off");
    a_syncpd_frees: assert property (o_sync_pd && $past(o_sync_pd, 2) |-> o_chan_hold == '0)
        else $error("channel held while sync is off");
    a_sync_from_hold: assert property ((o_chan_sync & ~($past(o_chan_hold) | $past(o_chan_hold, 2))) == '0)
        else $error("sync pulse on a channel that was not held");
    a_sync_one_cycle: assert property (o_chan_sync != '0 |=> o_chan_sync == '0)
        else $error("sync pulse longer than one cycle");
    a_direct_exclusive: assert property ((o_chan_osc_direct & o_chan_ext_direct) == '0)
        else $error("channel fed direct from both sources");

    c_sync: cover property (o_chan_sync != '0);
    c_osc_direct: cover property (o_chan_osc_direct != '0);
    c_div_edge: cover property ($rose(o_prediv_out));
endmodule

bind cidc_top cidc_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_rready(i_rready), .o_prediv_out(o_prediv_out),
    .o_input_section_pd(o_input_section_pd), .o_sync_pd(o_sync_pd), .o_chan_hold(o_chan_hold),
    .o_chan_sync(o_chan_sync), .o_chan_osc_direct(o_chan_osc_direct), .o_chan_ext_direct(o_chan_ext_direct));

// ---- testbench/cidc_top_test.sv ----
// self-checking bench for the clock input divider control
`include "cidc_defs.vh"
module cidc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [13:0] A_RAT = {`CIDC_IDX_RATIO, 2'h0}, A_PATH = {`CIDC_IDX_INPATH, 2'h0};
    localparam [13:0] A_SYS = {`CIDC_IDX_SYSPWR, 2'h0}, A_UPD = {`CIDC_IDX_UPDATE, 2'h0};
    localparam [13:0] A_CHAN = {`CIDC_IDX_CHAN, 2'h0}, A_BAD = 14'h3FFC, A_STAT = {`CIDC_IDX_STATUS, 2'h0};
    logic i_sys_clk = 1'h0, i_rst = 1'h1, i_ext_clk = 1'h0, i_osc_clk = 1'h0, i_sync_n = 1'h1;
    logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
    logic [13:0] i_awaddr = 14'h0, i_araddr = 14'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hF;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_prediv_out, o_input_section_pd;
    wire o_clk_if_pd, o_src_pd, o_src_sel_osc, o_bypass, o_sync_pd, o_dist_ref_pd;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire [2:0] o_chan_hold, o_chan_sync, o_chan_osc_direct, o_chan_ext_direct;
    wire [4:0] path_o = {o_input_section_pd, o_clk_if_pd, o_src_pd, o_src_sel_osc, o_bypass};
    int fails = 0, tests_run = 0, rises = 0, ph = 0;
    logic prev_out = 1'h0;
    logic [31:0] d;

    cidc_top #(.ADDR_W(14), .NUM_CHAN(3)) i_dut (.i_sys_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_ext_clk, .i_osc_clk, .i_sync_n,
        .o_prediv_out, .o_input_section_pd, .o_clk_if_pd, .o_src_pd, .o_src_sel_osc, .o_bypass, .o_sync_pd,
        .o_dist_ref_pd, .o_chan_hold, .o_chan_sync, .o_chan_osc_direct, .o_chan_ext_direct);

    always #25 i_sys_clk = ~i_sys_clk;

    // slow test clocks: oscillator period 8 cycles, external 6, so the counts tell them apart
    always @(posedge i_sys_clk)
    begin
        ph <= ph + 1;
        if (ph % 4 == 3)
            i_osc_clk <= ~i_osc_clk;
        if (ph % 3 == 2)
            i_ext_clk <= ~i_ext_clk;
        prev_out <= o_prediv_out;
        if (o_prediv_out && !prev_out)
            rises <= rises + 1;
    end

    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // edge counts may slip by one where the window cuts a divider period
    task chk_near(input string n, input int e, input int g);
        tests_run++;
        if (g < e - 1 || g > e + 1)
        begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task wr(input logic [13:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge i_sys_clk);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge i_sys_clk);
            if (o_awready)
                i_awvalid <= 1'h0;
            if (o_wready)
                i_wvalid <= 1'h0;
            if (o_bvalid)
                break;
        end
        i_bready <= 1'h0;
        if (n == 50)
        begin
            fails++;
            end_sim;
        end
        chk("bresp", er, o_bresp);
    endtask

    task rd(input logic [13:0] a, input logic [1:0] er, output logic [31:0] v);
        int n;
        @(posedge i_sys_clk);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge i_sys_clk);
            if (o_arready)
                i_arvalid <= 1'h0;
            if (o_rvalid)
                break;
        end
        i_rready <= 1'h0;
        if (n == 50)
        begin
            fails++;
            end_sim;
        end
        v = o_rdata;
        chk("rresp", er, o_rresp);
    endtask

    task rdchk(input string n, input logic [13:0] a, input logic [31:0] e);
        rd(a, `CIDC_RESP_OKAY, d);
        chk(n, e, d);
    endtask

    task cfg(input logic [13:0] a, input logic [31:0] v);
        wr(a, v, `CIDC_RESP_OKAY);
        wr(A_UPD, 32'h1, `CIDC_RESP_OKAY);
        repeat (4) @(posedge i_sys_clk);
    endtask

    task catch_sync(output logic [2:0] s);
        s = 3'h0;
        repeat (20)
        begin
            @(posedge i_sys_clk);
            s = s | o_chan_sync;
        end
    endtask

    task t_reset;
        rdchk("ratio", A_RAT, {29'h0, `CIDC_RATIO_RST});
        rdchk("path", A_PATH, 32'h0);
        rdchk("system", A_SYS, 32'h0);
        rd(A_BAD, `CIDC_RESP_SLVERR, d);
        chk("unmapped rdata", 32'h0, d);
        wr(A_BAD, 32'hFF, `CIDC_RESP_SLVERR);
    endtask

    task t_buffer;
        wr(A_PATH, 32'h0C, `CIDC_RESP_OKAY);
        repeat (4) @(posedge i_sys_clk);
        chk("pd before update", 32'h0, {o_clk_if_pd, o_src_pd});
        rdchk("path buffer", A_PATH, 32'h0C);
        wr(A_UPD, 32'h1, `CIDC_RESP_OKAY);
        repeat (4) @(posedge i_sys_clk);
        chk("pd after update", 32'h3, {o_clk_if_pd, o_src_pd});
        rdchk("update cleared", A_UPD, 32'h0);
    endtask

    task t_bits;
        // single bits only, so the oscillator is never chosen with bypass set
        for (int b = 0; b < 5; b++)
        begin
            cfg(A_PATH, 32'h1 << b);
            chk("path outputs", 32'h1 << b, path_o);
        end
        for (int b = 1; b < 3; b++)
        begin
            cfg(A_SYS, 32'h1 << b);
            chk("system outputs", 32'h1 << (b - 1), {o_sync_pd, o_dist_ref_pd});
        end
        cfg(A_SYS, 32'h0);
    endtask

    task t_div;
        int r0;
        int paths[4] = '{32'h0, 32'h1, 32'h11, 32'h05};
        int exps[4] = '{20, 80, 0, 0};
        cfg(A_PATH, 32'h2);
        // static codes come last, once the oscillator path is running
        for (int c = 0; c < 8; c++)
        begin
            cfg(A_RAT, c);
            r0 = rises;
            repeat (480) @(posedge i_sys_clk);
            chk_near("osc divided edges", (c < 5) ? 60 / (c + 2) : 0, rises - r0);
            if (c == 7)
                rdchk("static status", A_STAT, 32'h4);
        end
        chk("static level", 32'h0, o_prediv_out);
        cfg(A_RAT, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            cfg(A_PATH, paths[i]);
            r0 = rises;
            repeat (480) @(posedge i_sys_clk);
            chk_near("ext path edges", exps[i], rises - r0);
            if (exps[i] == 0)
                chk("quiet level", 32'h0, o_prediv_out);
        end
    endtask

    task t_sync;
        logic [2:0] s;
        cfg(A_PATH, 32'h0);
        cfg(A_CHAN, 32'h4);
        cfg(A_SYS, 32'h1);
        chk("soft hold", 32'h3, o_chan_hold);
        wr(A_SYS, 32'h0, `CIDC_RESP_OKAY);
        wr(A_UPD, 32'h1, `CIDC_RESP_OKAY);
        catch_sync(s);
        chk("soft sync pulse", 32'h3, s);
        chk("hold released", 32'h0, o_chan_hold);
        i_sync_n <= 1'h0;
        repeat (10) @(posedge i_sys_clk);
        chk("pin hold", 32'h3, o_chan_hold);
        i_sync_n <= 1'h1;
        catch_sync(s);
        chk("pin sync pulse", 32'h3, s);
        cfg(A_SYS, 32'h5);
        chk("sync off hold", 32'h0, o_chan_hold);
        cfg(A_SYS, 32'h0);
    endtask

    task t_direct;
        cfg(A_CHAN, 32'h100);
        cfg(A_PATH, 32'h2);
        chk("osc direct", 32'h08, {o_chan_osc_direct, o_chan_ext_direct});
        cfg(A_PATH, 32'h0);
        chk("ext direct", 32'h01, {o_chan_osc_direct, o_chan_ext_direct});
        cfg(A_PATH, 32'h1);
        chk("no direct", 32'h00, {o_chan_osc_direct, o_chan_ext_direct});
    endtask

    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        t_reset;
        t_buffer;
        t_bits;
        t_div;
        t_sync;
        t_direct;
        end_sim;
    end

    initial
    begin
        repeat (60000) @(posedge i_sys_clk);
        fails++;
        end_sim;
    end
endmodule
